// file: inc/pwr_mode_pkg.sv
/*
 * package for the power reduction mode controller: state encoding,
 * register offsets, field positions, reset values and timing counts.
 * assumes a 20 MHz system clock and a 32-bit axi4-lite register bus.
 */
package pwr_mode_pkg;

    // system clock period and wake pulse minimum
    localparam int unsigned CLK_PERIOD_NS      = 50;
    localparam int unsigned WAKE_PULSE_MIN_NS  = 40;
    localparam int unsigned WAKE_PULSE_CYCLES  =
        ((WAKE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((WAKE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // retained ram size in bytes
    localparam int unsigned RETAINED_RAM_BYTES = 16384;

    // register byte offsets
    localparam logic [7:0] SYSCFG_OFFSET   = 8'h00;
    localparam logic [7:0] MISC_OFFSET     = 8'h04;
    localparam logic [7:0] PERCFG_OFFSET   = 8'h08;
    localparam logic [7:0] STATUS_OFFSET   = 8'h0C;
    localparam logic [7:0] FIRQ_EN_OFFSET  = 8'h10;
    localparam logic [7:0] FIRQ_POL_OFFSET = 8'h14;
    localparam logic [7:0] COMMAND_OFFSET  = 8'h18;

    // field positions
    localparam int unsigned POWERDOWN_CONFIG_BIT_POS     = 5;
    localparam int unsigned REGOFF_POS     = 0;
    localparam int unsigned RAMEN_POS      = 0;
    localparam int unsigned LPOSC_DIS_POS  = 1;
    localparam int unsigned CMD_IDLE_POS   = 0;
    localparam int unsigned CMD_POWERDOWN_ENTRY_INSTR_POS  = 1;

    // reset values
    localparam logic [15:0] SYSCFG_RESET   = 16'h0000;
    localparam logic [15:0] MISC_RESET     = 16'h0000;
    localparam logic [15:0] PERCFG_RESET   = 16'h0000;
    localparam logic [7:0]  FIRQ_EN_RESET  = 8'h00;
    localparam logic [7:0]  FIRQ_POL_RESET = 8'hFF;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PM_RUN,
        PM_IDLE,
        PM_PD_PROT,
        PM_PD_INT
    } pm_state_type;

    // software controls
    typedef struct packed {
        logic [15:0] syscfg;
        logic [15:0] misc;
        logic [15:0] percfg;
        logic [7:0]  firq_en;
        logic [7:0]  firq_pol;
    } ctrl_type;

    // clock and supply controls driven out of the block
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic main_osc_en;
        logic rtc_clk_en;
        logic rtc_use_lp;
        logic ram_frozen;
        logic ram_on_standby;
    } gate_type;

endpackage

// file: src/pwr_mode_ctrl.sv
/*
 * power reduction mode controller: idle, protected and interruptible
 * power-down, and retained ram freeze / supply switching for standby.
 * assumes pins and analog comparators reach it asynchronously and are
 * synchronised here; cpu strobes and bus status are on mclk.
 */
`timescale 1ns/1ns
module pwr_mode_ctrl
    import pwr_mode_pkg::*;
#(
    parameter int unsigned FIRQ_N = 8
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // axi4-lite write address, data and response
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // cpu side
    input  wire logic              irq_req,
    input  wire logic              bus_busy,
    input  wire logic              ready_enabled,
    input  wire logic              ready_seen,
    // pins and wake sources (asynchronous)
    input  wire logic              reset_input_pin_n,
    input  wire logic              nmi_pin_n,
    input  wire logic [FIRQ_N-1:0] fast_ext_irq_pin,
    input  wire logic              rtc_irq,
    input  wire logic              can_i2c_irq,
    input  wire logic              lp_osc_running,
    input  wire logic              core_supply_low,
    // controls and status
    output gate_type               gate,
    output pm_state_type           pm_state,
    output logic                   entry_refused
);

    // synchroniser stages
    typedef struct packed {
        logic [1:0]        rstpin;
        logic [1:0]        nmi;
        logic [1:0]        lposc;
        logic [1:0]        low;
        logic [1:0]        rtc;
        logic [1:0]        canic;
        logic [FIRQ_N-1:0] firq1;
        logic [FIRQ_N-1:0] firq2;
    } sync_type;

    typedef struct packed {
        sync_type     sy;
        ctrl_type     ctrl;
        pm_state_type st;
        logic         idle_pend;
        logic         pd_pend;
        logic         lp_sel;
        logic         rst_seen;
        logic         refused;
        gate_type     gate;
        logic         awr;
        logic         wr;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
        logic [7:0]   aw_addr;
        logic         aw_have;
        logic [31:0]  w_data;
        logic         w_have;
        logic         low_hold;
    } state_type;

    state_type s_q;
    state_type s_d;

    logic              pin_rst;
    logic              firq_active;
    logic [FIRQ_N-1:0] firq_lvl;
    logic              wake_int;
    logic              gate_ok;
    logic [31:0]       wd;
    logic [31:0]       rd;
    logic [1:0]        rr;

    // per-pin active level after polarity and enable
    genvar gi;
    generate
        for (gi = 0; gi < FIRQ_N; gi++) begin : g_firq
            assign firq_lvl[gi] = s_q.ctrl.firq_en[gi]
                & ~(s_q.sy.firq2[gi] ^ s_q.ctrl.firq_pol[gi]);
        end
    endgenerate

    // decoded wake and entry conditions
    always_comb begin
        pin_rst     = ~s_q.sy.rstpin[1];
        firq_active = |firq_lvl;
        // one sampled active level (>= 40 ns at 50 ns clock) wakes
        wake_int    = firq_active | s_q.sy.rtc[1] | s_q.sy.canic[1];
        // bus drained and ready handshake seen
        gate_ok     = ~bus_busy & ~(ready_enabled & ~ready_seen);
    end

    // register read mux
    always_comb begin
        rd = 32'h0000_0000;
        rr = RESP_OKAY;
        if (s_axi_araddr == SYSCFG_OFFSET) begin
            rd[15:0] = s_q.ctrl.syscfg;
        end else if (s_axi_araddr == MISC_OFFSET) begin
            rd[15:0] = s_q.ctrl.misc;
        end else if (s_axi_araddr == PERCFG_OFFSET) begin
            rd[15:0] = s_q.ctrl.percfg;
        end else if (s_axi_araddr == STATUS_OFFSET) begin
            rd[7:0] = {s_q.gate.ram_on_standby, s_q.gate.ram_frozen, s_q.lp_sel,
                       s_q.refused, s_q.rst_seen, 1'b0, s_q.st};
        end else if (s_axi_araddr == FIRQ_EN_OFFSET) begin
            rd[7:0] = s_q.ctrl.firq_en;
        end else if (s_axi_araddr == FIRQ_POL_OFFSET) begin
            rd[7:0] = s_q.ctrl.firq_pol;
        end else if (s_axi_araddr == COMMAND_OFFSET) begin
            rd = 32'h0000_0000;
        end else begin
            rr = RESP_SLVERR;
        end
    end

    // next state
    always_comb begin
        s_d = s_q;
        wd  = s_q.w_data;

        // two-flop synchronisers
        s_d.sy.rstpin = {s_q.sy.rstpin[0], reset_input_pin_n};
        s_d.sy.nmi    = {s_q.sy.nmi[0], nmi_pin_n};
        s_d.sy.lposc  = {s_q.sy.lposc[0], lp_osc_running};
        s_d.sy.low    = {s_q.sy.low[0], core_supply_low};
        s_d.sy.rtc    = {s_q.sy.rtc[0], rtc_irq};
        s_d.sy.canic  = {s_q.sy.canic[0], can_i2c_irq};
        s_d.sy.firq1  = fast_ext_irq_pin;
        s_d.sy.firq2  = s_q.sy.firq1;

        // axi write channels, taken in either order
        s_d.awr = 1'b0;
        s_d.wr  = 1'b0;
        if (s_axi_awvalid & s_q.awr) begin
            s_d.aw_addr = s_axi_awaddr;
            s_d.aw_have = 1'b1;
        end
        if (s_axi_wvalid & s_q.wr) begin
            s_d.w_data = s_axi_wdata;
            s_d.w_have = 1'b1;
            wd         = s_axi_wdata;
        end
        if (s_q.bvalid & s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (~s_q.aw_have & ~s_q.bvalid & ~(s_axi_awvalid & s_q.awr)) begin
            s_d.awr = 1'b1;
        end
        if (~s_q.w_have & ~s_q.bvalid & ~(s_axi_wvalid & s_q.wr)) begin
            s_d.wr = 1'b1;
        end

        // commit a write once address and data are both held
        if (s_q.aw_have & s_q.w_have) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = RESP_OKAY;
            if (s_q.aw_addr == SYSCFG_OFFSET) begin
                s_d.ctrl.syscfg = wd[15:0];
            end else if (s_q.aw_addr == MISC_OFFSET) begin
                s_d.ctrl.misc = wd[15:0];
            end else if (s_q.aw_addr == PERCFG_OFFSET) begin
                s_d.ctrl.percfg = wd[15:0];
            end else if (s_q.aw_addr == FIRQ_EN_OFFSET) begin
                s_d.ctrl.firq_en = wd[7:0];
            end else if (s_q.aw_addr == FIRQ_POL_OFFSET) begin
                s_d.ctrl.firq_pol = wd[7:0];
            end else if (s_q.aw_addr == COMMAND_OFFSET) begin
                s_d.idle_pend = s_q.idle_pend | wd[CMD_IDLE_POS];
                s_d.pd_pend   = s_q.pd_pend | wd[CMD_POWERDOWN_ENTRY_INSTR_POS];
            end else if (s_q.aw_addr == STATUS_OFFSET) begin
                s_d.refused = 1'b0; // status write clears the refusal flag
            end else begin
                s_d.bresp = RESP_SLVERR;
            end
        end

        // axi read channel
        if (s_q.rvalid & s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid & s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd;
            s_d.rresp  = rr;
        end

        // lp oscillator taken as rtc reference once seen, software may drop
        if (s_q.sy.lposc[1]) begin
            s_d.lp_sel = 1'b1;
        end
        if (s_q.ctrl.percfg[LPOSC_DIS_POS]) begin
            s_d.lp_sel = 1'b0;
        end

        // mode machine
        case (s_q.st)
            PM_RUN: begin
                if (s_q.idle_pend | s_q.pd_pend) begin
                    if (gate_ok) begin
                        s_d.idle_pend = 1'b0;
                        s_d.pd_pend   = 1'b0;
                        if (s_q.pd_pend) begin
                            if (~s_q.ctrl.syscfg[POWERDOWN_CONFIG_BIT_POS]) begin
                                if (~s_q.sy.nmi[1]) begin
                                    s_d.st = PM_PD_PROT;
                                end else begin
                                    s_d.refused = 1'b1;
                                end
                            end else if (~firq_active) begin
                                s_d.st = PM_PD_INT;
                            end else begin
                                s_d.refused = 1'b1;
                            end
                        end else begin
                            s_d.st = PM_IDLE;
                        end
                    end else if (~bus_busy) begin
                        s_d.idle_pend = 1'b0; // ready missed: entry refused
                        s_d.pd_pend   = 1'b0;
                        s_d.refused   = 1'b1;
                    end
                end
            end
            PM_IDLE: begin
                if (irq_req) begin
                    s_d.st = PM_RUN;
                end
            end
            PM_PD_PROT: begin
                s_d.st = PM_PD_PROT; // only reset leaves
            end
            PM_PD_INT: begin
                if (wake_int) begin
                    s_d.st = PM_RUN;
                end
            end
            default: begin
                s_d.st = PM_RUN;
            end
        endcase

        // reset pin returns every mode to run
        if (pin_rst) begin
            s_d.st        = PM_RUN;
            s_d.idle_pend = 1'b0;
            s_d.pd_pend   = 1'b0;
            s_d.rst_seen  = 1'b1;
            s_d.ctrl.percfg[RAMEN_POS] = 1'b0;
        end

        // clock gating from the next mode
        s_d.gate.cpu_clk_en    = (s_d.st == PM_RUN);
        s_d.gate.periph_clk_en = (s_d.st == PM_RUN) | (s_d.st == PM_IDLE);
        s_d.gate.rtc_use_lp    = s_d.lp_sel;
        s_d.gate.rtc_clk_en    = 1'b1;
        if ((s_d.st == PM_PD_PROT) | (s_d.st == PM_PD_INT)) begin
            s_d.gate.main_osc_en = ~s_d.lp_sel;
        end else begin
            s_d.gate.main_osc_en = 1'b1;
        end

        // a dip holds the ram frozen from its first sample with the enable bit clear until the supply
        // recovers, whatever the enable bit reads afterwards; while the bit stays set the dip is ignored
        s_d.low_hold = s_q.sy.low[1] & (s_q.low_hold | ~s_q.ctrl.percfg[RAMEN_POS]);
        // retained ram: standby supply under reset or held dip, main once released
        s_d.gate.ram_on_standby = pin_rst | s_d.low_hold;
        s_d.gate.ram_frozen = ~s_d.ctrl.percfg[RAMEN_POS]
            | s_d.low_hold | pin_rst;
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q                     <= '0;
            s_q.sy.rstpin           <= 2'h3;
            s_q.sy.nmi              <= 2'h3;
            s_q.ctrl.syscfg         <= SYSCFG_RESET;
            s_q.ctrl.misc           <= MISC_RESET;
            s_q.ctrl.percfg         <= PERCFG_RESET;
            s_q.ctrl.firq_en        <= FIRQ_EN_RESET;
            s_q.ctrl.firq_pol       <= FIRQ_POL_RESET;
            s_q.st                  <= PM_RUN;
            s_q.rst_seen            <= 1'b1;
            s_q.gate.cpu_clk_en     <= 1'b1;
            s_q.gate.periph_clk_en  <= 1'b1;
            s_q.gate.main_osc_en    <= 1'b1;
            s_q.gate.rtc_clk_en     <= 1'b1;
            s_q.gate.ram_frozen     <= 1'b1;
            s_q.gate.ram_on_standby <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign s_axi_awready = s_q.awr;
    assign s_axi_wready  = s_q.wr;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = ~s_q.rvalid;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign gate          = s_q.gate;
    assign pm_state      = s_q.st;
    assign entry_refused = s_q.refused;

endmodule

// file: sim/pwr_mode_ctrl_assertions.sv
/* checker for the power mode controller: entry conditions, gating, ram freeze.
   bound to pwr_mode_ctrl; sees only its ports, one clock domain. */
`timescale 1ns/1ns
module pwr_mode_ctrl_assertions
    import pwr_mode_pkg::*;
(
    // clock and reset
    input wire logic         mclk,
    input wire logic         rst,
    // cpu side and pins
    input wire logic         irq_req,
    input wire logic         bus_busy,
    input wire logic         ready_enabled,
    input wire logic         ready_seen,
    input wire logic         reset_input_pin_n,
    input wire logic         nmi_pin_n,
    // controls and status
    input wire gate_type     gate,
    input wire pm_state_type pm_state
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // run to a low-power mode in one step, and modes held over two samples
    sequence s_enter;
        pm_state == PM_RUN ##1 pm_state != PM_RUN;
    endsequence
    sequence s_idle;
        pm_state == PM_IDLE ##1 pm_state == PM_IDLE;
    endsequence
    sequence s_pd;
        pm_state inside {PM_PD_PROT, PM_PD_INT} ##1 pm_state inside {PM_PD_PROT, PM_PD_INT};
    endsequence

    a_idle_gates: assert property (s_idle |-> !gate.cpu_clk_en && gate.periph_clk_en)
        else $error("idle gating wrong");
    a_idle_wake: assert property (pm_state == PM_IDLE && irq_req |-> ##[1:3] pm_state == PM_RUN)
        else $error("idle not left on interrupt");
    a_busy_entry: assert property (s_enter |-> !$past(bus_busy))
        else $error("mode entered with bus busy");
    a_ready_entry: assert property (s_enter |-> !$past(ready_enabled) || $past(ready_seen))
        else $error("mode entered with ready missed");
    a_pd_gates: assert property (s_pd |-> !gate.cpu_clk_en && !gate.periph_clk_en)
        else $error("power-down clocks running");
    a_pd_osc: assert property (s_pd |-> gate.main_osc_en == !gate.rtc_use_lp)
        else $error("power-down oscillator wrong");
    a_prot_nmi: assert property (pm_state == PM_RUN ##1 pm_state == PM_PD_PROT |-> !$past(nmi_pin_n, 3))
        else $error("protected entry without nmi");
    a_prot_hold: assert property (pm_state == PM_PD_PROT && reset_input_pin_n && $past(reset_input_pin_n) && $past(reset_input_pin_n, 2) |=> pm_state == PM_PD_PROT)
        else $error("protected power-down left without reset");
    a_ram_reset: assert property (!reset_input_pin_n [*3] |=> gate.ram_frozen && gate.ram_on_standby)
        else $error("ram not frozen in reset");
    a_ram_supply: assert property (!gate.ram_frozen |-> !gate.ram_on_standby)
        else $error("ram open on standby supply");
endmodule

bind pwr_mode_ctrl pwr_mode_ctrl_assertions u_chk (
    .mclk(mclk), .rst(rst), .irq_req(irq_req), .bus_busy(bus_busy),
    .ready_enabled(ready_enabled), .ready_seen(ready_seen), .nmi_pin_n(nmi_pin_n),
    .reset_input_pin_n(reset_input_pin_n), .gate(gate), .pm_state(pm_state)
);

// file: sim/wake_src_model.sv
/* model of the reset circuit and wake sources at the block's pins.
   driven by the bench on mclk; a one-cycle go launches one pulse. */
`timescale 1ns/1ns
module wake_src_model (
    // clock and bench controls
    input  wire logic       mclk,
    input  wire logic       ramp,
    input  wire logic       go,
    input  wire logic [1:0] kind,
    input  wire logic [2:0] sel,
    input  wire logic [7:0] firq_hold,
    // pins towards the block
    output logic            pin_n,
    output logic [7:0]      firq,
    output logic            rtc_irq,
    output logic            can_irq
);
    logic [2:0] left_q = 3'h0;
    logic [1:0] kind_q = 2'h0;
    logic [2:0] sel_q  = 3'h0;
    logic       on;

    // reset pulse outlasts the pin synchroniser, wake pulses last two cycles
    always @(posedge mclk) begin
        if (go) begin
            left_q <= (kind == 2'h3) ? 3'h7 : 3'h2;
            kind_q <= kind;
            sel_q  <= sel;
        end else if (left_q != 3'h0) begin
            left_q <= left_q - 3'h1;
        end
    end

    // reset pin kept low through the whole power ramp
    assign on      = left_q != 3'h0;
    assign pin_n   = !(ramp || (on && kind_q == 2'h3));
    assign rtc_irq = on && kind_q == 2'h1;
    assign can_irq = on && kind_q == 2'h2;
    always_comb begin
        firq = firq_hold;
        if (on && kind_q == 2'h0) begin
            firq[sel_q] = 1'b1;
        end
    end
endmodule

// file: sim/tb.sv
/* self-checking bench for the power mode controller over axi4-lite.
   assumes the wake source model and the bound checker are compiled in. */
`timescale 1ns/1ns
module tb
    import pwr_mode_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  aw_addr = 8'h00;
    logic [7:0]  ar_addr = 8'h00;
    logic [31:0] w_data = 32'h0;
    logic        aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0;
    logic        r_ready = 1'b0, irq_req = 1'b0, bus_busy = 1'b0, rdy_en = 1'b0;
    logic        rdy_seen = 1'b1, nmi_n = 1'b1, lp_run = 1'b0, core_low = 1'b0;
    logic        ramp = 1'b1, go = 1'b0;
    logic [1:0]  kind = 2'h0;
    logic [2:0]  sel = 3'h0;
    logic [7:0]  firq_hold = 8'h00;
    logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, refused, pin_n, rtc_irq, can_irq;
    logic [1:0]  b_resp, r_resp, r;
    logic [31:0] r_data, d;
    logic [7:0]  firq;
    gate_type    gate;
    pm_state_type st;
    int          miscompares = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #25 mclk = ~mclk;

    pwr_mode_ctrl u_dut (
        .mclk(mclk), .rst(rst), .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
        .s_axi_awready(aw_ready), .s_axi_wdata(w_data), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
        .s_axi_bvalid(b_valid), .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
        .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready), .s_axi_rdata(r_data),
        .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready),
        .irq_req(irq_req), .bus_busy(bus_busy), .ready_enabled(rdy_en), .ready_seen(rdy_seen),
        .reset_input_pin_n(pin_n), .nmi_pin_n(nmi_n), .fast_ext_irq_pin(firq),
        .rtc_irq(rtc_irq), .can_i2c_irq(can_irq), .lp_osc_running(lp_run),
        .core_supply_low(core_low), .gate(gate), .pm_state(st), .entry_refused(refused)
    );
    wake_src_model u_src (
        .mclk(mclk), .ramp(ramp), .go(go), .kind(kind), .sel(sel), .firq_hold(firq_hold),
        .pin_n(pin_n), .firq(firq), .rtc_irq(rtc_irq), .can_irq(can_irq)
    );

    task automatic give_verdict();
        if (miscompares == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge mclk);
        aw_addr <= a;
        w_data <= v;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        do begin
            @(posedge mclk);
            if (aw_ready === 1'b1) aw_valid <= 1'b0;
            if (w_ready === 1'b1) w_valid <= 1'b0;
        end while (b_valid !== 1'b1);
        b_ready <= 1'b0;
        chk("bresp", 32'(er), 32'(b_resp));
    endtask

    // read: result left in d and r
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        do begin
            @(posedge mclk);
            if (ar_ready === 1'b1) ar_valid <= 1'b0;
        end while (r_valid !== 1'b1);
        r_ready <= 1'b0;
        d = r_data;
        r = r_resp;
    endtask

    task automatic wait_st(input pm_state_type s);
        int n;
        n = 0;
        while (st !== s && n < 60) begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
        chk("pm_state", 32'(s), 32'(st));
    endtask

    task automatic pulse(input logic [1:0] k, input logic [2:0] s);
        @(posedge mclk);
        kind <= k;
        sel <= s;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
    endtask

    // reset values, status encoding and an unmapped place
    task automatic t_reset();
        chk("gate", 32'h7A, 32'(gate) & 32'h7E);
        rd(STATUS_OFFSET);
        chk("status", 32'h40, d & 32'hFFFFFF77);
        rd(FIRQ_POL_OFFSET);
        chk("firq_pol", 32'hFF, d);
        rd(8'h40);
        chk("rresp", 32'(RESP_SLVERR), 32'(r));
        wr(8'h44, 32'h1, RESP_SLVERR);
    endtask

    // idle held off by a busy bus, then woken by an interrupt
    task automatic t_idle();
        bus_busy <= 1'b1;
        wr(COMMAND_OFFSET, 32'h1, RESP_OKAY);
        cyc(6);
        chk("pm_state", 32'(PM_RUN), 32'(st));
        bus_busy <= 1'b0;
        wait_st(PM_IDLE);
        chk("idle_gate", 32'h20, 32'(gate) & 32'h60);
        irq_req <= 1'b1;
        wait_st(PM_RUN);
        irq_req <= 1'b0;
        chk("cpu_clk_en", 32'h1, 32'(gate.cpu_clk_en));
    endtask

    // entry refused while the ready handshake was missed
    task automatic t_refuse();
        rdy_en <= 1'b1;
        rdy_seen <= 1'b0;
        wr(COMMAND_OFFSET, 32'h1, RESP_OKAY);
        cyc(8);
        chk("pm_state", 32'(PM_RUN), 32'(st));
        chk("refused", 32'h1, 32'(refused));
        rdy_seen <= 1'b1;
        wr(STATUS_OFFSET, 32'h0, RESP_OKAY);
        wr(COMMAND_OFFSET, 32'h1, RESP_OKAY);
        wait_st(PM_IDLE);
        irq_req <= 1'b1;
        wait_st(PM_RUN);
        irq_req <= 1'b0;
    endtask

    // protected power-down: needs nmi low, ignores wake sources, left by reset
    task automatic t_prot();
        wr(MISC_OFFSET, 32'h1, RESP_OKAY);
        wr(FIRQ_EN_OFFSET, 32'h1, RESP_OKAY);
        wr(COMMAND_OFFSET, 32'h2, RESP_OKAY);
        cyc(8);
        chk("pm_state", 32'(PM_RUN), 32'(st));
        chk("refused", 32'h1, 32'(refused));
        wr(STATUS_OFFSET, 32'h0, RESP_OKAY);
        nmi_n <= 1'b0;
        cyc(4);
        wr(COMMAND_OFFSET, 32'h2, RESP_OKAY);
        wait_st(PM_PD_PROT);
        chk("pd_gate", 32'h10, 32'(gate) & 32'h74);
        for (int k = 0; k < 3; k++) begin
            pulse(2'(k), 3'h0);
            cyc(6);
            chk("pm_state", 32'(PM_PD_PROT), 32'(st));
        end
        nmi_n <= 1'b1;
        pulse(2'h3, 3'h0);
        wait_st(PM_RUN);
        cyc(8);
    endtask

    // interruptible power-down with the 32 kHz reference, every wake source
    task automatic t_intr();
        lp_run <= 1'b1;
        wr(SYSCFG_OFFSET, 32'h20, RESP_OKAY);
        wr(FIRQ_EN_OFFSET, 32'h4, RESP_OKAY);
        firq_hold <= 8'h04;
        wr(COMMAND_OFFSET, 32'h2, RESP_OKAY);
        cyc(8);
        chk("pm_state", 32'(PM_RUN), 32'(st));
        firq_hold <= 8'hFB;
        wr(STATUS_OFFSET, 32'h0, RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            wr(COMMAND_OFFSET, 32'h2, RESP_OKAY);
            wait_st(PM_PD_INT);
            if (k == 0) chk("osc_sel", 32'h04, 32'(gate) & 32'h14);
            pulse(2'(k), 3'h2);
            wait_st(PM_RUN);
        end
        cyc(8);
        chk("rtc_use_lp", 32'h1, 32'(gate.rtc_use_lp));
        wr(PERCFG_OFFSET, 32'h2, RESP_OKAY);
        cyc(3);
        chk("rtc_use_lp", 32'h0, 32'(gate.rtc_use_lp));
    endtask

    // retained ram freeze against supply dips and reset
    task automatic t_ram();
        firq_hold <= 8'h00;
        wr(PERCFG_OFFSET, 32'h1, RESP_OKAY);
        cyc(4);
        chk("ram_gate", 32'h0, 32'(gate) & 32'h3);
        core_low <= 1'b1;
        cyc(6);
        chk("ram_frozen", 32'h0, 32'(gate.ram_frozen));
        wr(PERCFG_OFFSET, 32'h0, RESP_OKAY);
        wr(PERCFG_OFFSET, 32'h1, RESP_OKAY);
        cyc(4);
        chk("ram_frozen", 32'h1, 32'(gate.ram_frozen));
        core_low <= 1'b0;
        cyc(6);
        chk("ram_frozen", 32'h0, 32'(gate.ram_frozen));
        pulse(2'h3, 3'h0);
        cyc(5);
        chk("ram_gate", 32'h3, 32'(gate) & 32'h3);
        cyc(8);
        chk("ram_frozen", 32'h1, 32'(gate.ram_frozen));
    endtask

    // cycle ceiling against hangs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        cyc(12);
        ramp <= 1'b0;
        cyc(4);
        rst <= 1'b0;
        cyc(4);
        t_reset();
        t_idle();
        t_refuse();
        t_prot();
        t_intr();
        t_ram();
        give_verdict();
    end
endmodule
